// File: common/ptp_pkg.sv
// package: register map, control layout and constants of the periodic timer
package ptp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 8; // byte address width
  localparam int unsigned DATA_W = 32; // bus data width
  localparam int unsigned CNT_W = 16; // counter and compare width

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00; // control bits
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h04; // compare a / capture
  localparam logic [ADDR_W-1:0] OFS_CMP_P = 8'h08; // compare p / period
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0c; // live counter, read only
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10; // match flags, write one clears

  ////////////////////////////////////////////////////////////////////////////
  // status bit positions
  localparam int unsigned ST_FLAG_A = 0; // compare-a match or capture
  localparam int unsigned ST_FLAG_P = 1; // compare-p match

  ////////////////////////////////////////////////////////////////////////////
  // reset values and fixed counts
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000; // counter clear value
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001; // counter step
  localparam logic [CNT_W-1:0] PERIOD_MAX = 16'hffff; // period when compare p is zero
  localparam logic [6:0] PRESC_ZERO = 7'h00; // prescaler reset value
  localparam logic [6:0] PRESC_ONE = 7'h01; // prescaler step

  ////////////////////////////////////////////////////////////////////////////
  // operating mode, gray ordered
  typedef enum logic [1:0] {
    PTP_MODE_CMP = 2'h0, // compare match output
    PTP_MODE_CAP = 2'h1, // capture input
    PTP_MODE_TMR = 2'h3, // plain timer / counter
    PTP_MODE_PWM = 2'h2  // pwm, or single pulse with pin action 11
  } ptp_mode_t;

  // pin action codes
  localparam logic [1:0] PA_00 = 2'h0; // pwm: force low / cap: rising
  localparam logic [1:0] PA_01 = 2'h1; // pwm: force high / cap: falling
  localparam logic [1:0] PA_10 = 2'h2; // pwm: waveform / cap: both edges
  localparam logic [1:0] PA_11 = 2'h3; // pwm: waveform, single pulse / cap: off

  ////////////////////////////////////////////////////////////////////////////
  // control register layout, msb first
  typedef struct packed {
    logic trig_falling; // [12] trigger pin active edge is falling
    logic [2:0] presc_sel; // [11:9] timer clock = clk / 2**presc_sel
    logic counter_run; // [8] counter run control
    logic capture_src_sel; // [7] 0 capture pin, 1 trigger pin
    logic out_invert; // [6] output inversion
    logic out_init_level; // [5] output base level
    logic clear_src_sel; // [4] 1 clears on compare a (compare modes)
    logic [1:0] pin_action_sel; // [3:2] pin action / edge select
    ptp_mode_t op_mode_sel; // [1:0] operating mode
  } ptp_ctrl_t;

  localparam int unsigned CTRL_W = 13; // used control bits
  localparam ptp_ctrl_t CTRL_RST = '{trig_falling: 1'b0, presc_sel: 3'h0, counter_run: 1'b0,
    capture_src_sel: 1'b0, out_invert: 1'b0, out_init_level: 1'b0, clear_src_sel: 1'b0,
    pin_action_sel: 2'h0, op_mode_sel: PTP_MODE_CMP};

endpackage : ptp_pkg

// File: src/ptp_timer.sv
// periodic timer with pwm, single pulse and capture, on a wishbone slave
//
// Decided for this implementation: register access over Wishbone and the register offsets.

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - pwm period ends on compare-p; zero means 65535
// - compare a at or above period: full duty
// - pwm counting continues with pin forced
// - clear source ignored in pwm mode
// - single pulse is mode 10 with action 11
// - run rising starts counter and pulse together
// - trigger pin edge sets run automatically in single pulse mode
// - compare-a match ends pulse, clears run, flags
// - single pulse clears only on run rising
// - capture mode 01, source pin selectable
// - edge select; action 11 blocks captures
// - capture copies counter to compare a, flags
// - capture mode counter free runs while run
// - capture compare-p match clears counter, flags
// - capture ignores clear, level, invert bits
// - capture watches pin whatever its direction
// - pwm base level and inversion select polarity
// - pwm pin action enables or forces pin
module ptp_timer (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptp_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ptp_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ptp_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic ext_trigger_pin_i,
  input wire logic capture_in_pin_i,
  output logic timer_out_o
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  ptp_pkg::ptp_ctrl_t ctrl; // control register
  ptp_pkg::ptp_ctrl_t next_ctrl;
  logic [ptp_pkg::CNT_W-1:0] cmp_a_value; // compare a / capture value
  logic [ptp_pkg::CNT_W-1:0] next_cmp_a_value;
  logic [ptp_pkg::CNT_W-1:0] cmp_p_value; // compare p value
  logic [ptp_pkg::CNT_W-1:0] next_cmp_p_value;
  logic [ptp_pkg::CNT_W-1:0] cnt; // timer counter
  logic [ptp_pkg::CNT_W-1:0] next_cnt;
  logic [1:0] flags; // sticky match flags
  logic [1:0] next_flags;
  logic [6:0] presc; // clock prescaler
  logic [6:0] next_presc;
  logic run_d; // run bit one cycle ago
  logic next_run_d;
  logic out_q; // output pin register
  logic next_out_q;
  logic [ptp_pkg::DATA_W-1:0] next_dat;
  logic next_ack;

  // pin synchronisers: stage one feeds only stage two
  logic trig_s1, trig_s2, trig_s3;
  logic cap_s1, cap_s2, cap_s3;

  //////////////////////////////////////////////////////////////////////////////
  // decoded helpers
  logic bus_req; // new access this cycle
  logic wr_en; // write takes effect
  logic [ptp_pkg::DATA_W-1:0] wmask; // byte lane mask
  logic tick; // one timer clock period
  logic run_rise; // run bit went high
  logic mode_pulse; // single pulse mode active
  logic [ptp_pkg::CNT_W-1:0] period; // effective pwm period
  logic match_a; // counter equals compare a on a tick
  logic match_p; // counter equals nonzero compare p on a tick
  logic cap_pin; // selected capture source, synchronised
  logic cap_pin_d; // previous value of selected source
  logic cap_edge; // selected active capture edge
  logic trig_edge; // trigger pin active edge
  logic duty_on; // pwm active phase
  logic wave; // polarity-corrected waveform

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers plus one history flop for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_s3 <= 1'b0;
    end else if (ce_i) begin
      trig_s1 <= ext_trigger_pin_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      cap_s1 <= capture_in_pin_i; // pin read even while driven as output
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // combinational decode
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr_en = bus_req && wb_we_i;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // prescaled tick: low presc_sel bits all ones
    tick = ctrl.counter_run &&
      ((presc & ((ptp_pkg::PRESC_ONE << ctrl.presc_sel) - ptp_pkg::PRESC_ONE))
      == ((ptp_pkg::PRESC_ONE << ctrl.presc_sel) - ptp_pkg::PRESC_ONE));
    run_rise = ctrl.counter_run && !run_d;
    mode_pulse = (ctrl.op_mode_sel == ptp_pkg::PTP_MODE_PWM)
      && (ctrl.pin_action_sel == ptp_pkg::PA_11);
    period = (cmp_p_value == ptp_pkg::CNT_ZERO) ? ptp_pkg::PERIOD_MAX : cmp_p_value;
    match_a = tick && (cnt == cmp_a_value);
    match_p = tick && (cmp_p_value != ptp_pkg::CNT_ZERO) && (cnt == cmp_p_value);
    // selected source and its previous sample
    cap_pin = ctrl.capture_src_sel ? trig_s2 : cap_s2;
    cap_pin_d = ctrl.capture_src_sel ? trig_s3 : cap_s3;
    case (ctrl.pin_action_sel)
      ptp_pkg::PA_00: cap_edge = cap_pin && !cap_pin_d;
      ptp_pkg::PA_01: cap_edge = !cap_pin && cap_pin_d;
      ptp_pkg::PA_10: cap_edge = cap_pin != cap_pin_d;
      default: cap_edge = 1'b0; // captures suppressed
    endcase
    trig_edge = ctrl.trig_falling ? (!trig_s2 && trig_s3) : (trig_s2 && !trig_s3);
    duty_on = cnt < cmp_a_value; // full duty when a >= period
    wave = (duty_on ? ctrl.out_init_level : !ctrl.out_init_level) ^ ctrl.out_invert;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next values for counter, registers, flags and output
  always_comb begin
    next_ctrl = ctrl;
    next_cmp_a_value = cmp_a_value;
    next_cmp_p_value = cmp_p_value;
    next_cnt = cnt;
    next_flags = flags;
    next_out_q = out_q;
    next_presc = ctrl.counter_run ? presc + ptp_pkg::PRESC_ONE : ptp_pkg::PRESC_ZERO;
    next_run_d = ctrl.counter_run;

    // software writes first; hardware events below override them
    if (wr_en) begin
      case (wb_adr_i)
        ptp_pkg::OFS_CTRL: begin
          next_ctrl = ptp_pkg::ptp_ctrl_t'((ptp_pkg::CTRL_W'(ctrl) & ~wmask[12:0])
            | (wb_dat_i[12:0] & wmask[12:0]));
        end
        ptp_pkg::OFS_CMP_A: begin
          next_cmp_a_value = (cmp_a_value & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end
        ptp_pkg::OFS_CMP_P: begin
          next_cmp_p_value = (cmp_p_value & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end
        ptp_pkg::OFS_STATUS: begin
          next_flags = flags & ~(wb_dat_i[1:0] & wmask[1:0]); // write one clears
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end

    // counter engine per mode
    if (run_rise) begin
      next_cnt = ptp_pkg::CNT_ZERO; // restart on run rising
    end else if (mode_pulse) begin
      // single pulse: compare p and clear source unused
      if (match_a) begin
        next_ctrl.counter_run = 1'b0; // pulse width from compare a
        next_flags[ptp_pkg::ST_FLAG_A] = 1'b1;
      end else if (tick) begin
        next_cnt = cnt + ptp_pkg::CNT_ONE;
      end
    end else begin
      case (ctrl.op_mode_sel)
        ptp_pkg::PTP_MODE_PWM: begin
          // clear source ignored, period ends on compare p
          if (tick) begin
            next_cnt = (cnt == period - ptp_pkg::CNT_ONE) ? ptp_pkg::CNT_ZERO
              : cnt + ptp_pkg::CNT_ONE;
            if (cnt == period - ptp_pkg::CNT_ONE) begin
              next_flags[ptp_pkg::ST_FLAG_P] = 1'b1;
            end
            if (cnt == cmp_a_value) begin
              next_flags[ptp_pkg::ST_FLAG_A] = 1'b1;
            end
          end
        end
        ptp_pkg::PTP_MODE_CAP: begin
          // free runs regardless of the capture pin
          if (match_p) begin
            next_cnt = ptp_pkg::CNT_ZERO;
            next_flags[ptp_pkg::ST_FLAG_P] = 1'b1;
          end else if (tick) begin
            next_cnt = cnt + ptp_pkg::CNT_ONE; // wraps at full count when p is zero
          end
        end
        default: begin
          // compare and timer modes: clear on p, or on a when selected
          if (ctrl.clear_src_sel ? match_a : match_p) begin
            next_cnt = ptp_pkg::CNT_ZERO;
          end else if (tick) begin
            next_cnt = cnt + ptp_pkg::CNT_ONE;
          end
          if (match_a && (cmp_a_value != ptp_pkg::CNT_ZERO)) begin
            next_flags[ptp_pkg::ST_FLAG_A] = 1'b1;
          end
          if (match_p && !ctrl.clear_src_sel) begin
            next_flags[ptp_pkg::ST_FLAG_P] = 1'b1;
          end
        end
      endcase
    end

    // capture: latch counter into compare a, wins over a bus write
    if ((ctrl.op_mode_sel == ptp_pkg::PTP_MODE_CAP) && cap_edge) begin
      next_cmp_a_value = cnt;
      next_flags[ptp_pkg::ST_FLAG_A] = 1'b1;
    end

    // trigger pin sets run in single pulse mode only while run is low, winning over a bus write
    if (mode_pulse && trig_edge && !ctrl.counter_run) begin
      next_ctrl.counter_run = 1'b1;
    end

    // output pin per mode
    case (ctrl.op_mode_sel)
      ptp_pkg::PTP_MODE_PWM: begin
        if (mode_pulse) begin
          // pulse active while run is high, leading edge with run rise
          next_out_q = next_ctrl.counter_run ^ ctrl.out_invert ^ !ctrl.out_init_level;
        end else begin
          case (ctrl.pin_action_sel)
            ptp_pkg::PA_00: next_out_q = 1'b0; // forced low
            ptp_pkg::PA_01: next_out_q = 1'b1; // forced high
            default: next_out_q = wave; // waveform shown
          endcase
        end
      end
      ptp_pkg::PTP_MODE_CMP: begin
        if (run_rise) begin
          next_out_q = ctrl.out_init_level;
        end else if (match_a && (cmp_a_value != ptp_pkg::CNT_ZERO)) begin
          case (ctrl.pin_action_sel)
            ptp_pkg::PA_01: next_out_q = 1'b0;
            ptp_pkg::PA_10: next_out_q = 1'b1;
            ptp_pkg::PA_11: next_out_q = !out_q;
            default: next_out_q = out_q;
          endcase
        end
      end
      default: begin
        next_out_q = 1'b0; // no output function
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait-free ack, registered read data
  always_comb begin
    next_ack = bus_req;
    next_dat = '0;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        ptp_pkg::OFS_CTRL: next_dat = {19'h0, ptp_pkg::CTRL_W'(ctrl)};
        ptp_pkg::OFS_CMP_A: next_dat = {16'h0, cmp_a_value};
        ptp_pkg::OFS_CMP_P: next_dat = {16'h0, cmp_p_value};
        ptp_pkg::OFS_COUNT: next_dat = {16'h0, cnt};
        ptp_pkg::OFS_STATUS: next_dat = {30'h0, flags};
        default: next_dat = '0; // unmapped reads zero
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= ptp_pkg::CTRL_RST;
      cmp_a_value <= ptp_pkg::CNT_ZERO;
      cmp_p_value <= ptp_pkg::CNT_ZERO;
      cnt <= ptp_pkg::CNT_ZERO;
      flags <= 2'h0;
      presc <= ptp_pkg::PRESC_ZERO;
      run_d <= 1'b0;
      out_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
      cmp_a_value <= next_cmp_a_value;
      cmp_p_value <= next_cmp_p_value;
      cnt <= next_cnt;
      flags <= next_flags;
      presc <= next_presc;
      run_d <= next_run_d;
      out_q <= next_out_q;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  assign timer_out_o = out_q;

endmodule : ptp_timer

// File: tb/ptp_chk.sv
// checker: bus handshake and pin level properties of the timer
module ptp_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptp_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [ptp_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [ptp_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pin
  input wire logic timer_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ptp_pkg::ptp_ctrl_t shadow; // control word as last written
  ptp_pkg::ptp_ctrl_t next_shadow; // shadow after this edge
  ////////////////////////////////////////////////////////////////////////////////
  // follow control writes as they land
  always_comb begin
    next_shadow = shadow;
    if (wb_ack_o && wb_we_i && wb_adr_i == ptp_pkg::OFS_CTRL) begin
      next_shadow = ptp_pkg::ptp_ctrl_t'(wb_dat_i[12:0]);
    end
  end
  // register the shadow, cleared by reset
  always_ff @(posedge clk_i) begin
    shadow <= rst_i ? ptp_pkg::CTRL_RST : next_shadow;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  // a fresh request
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // pwm mode held with one pin action
  sequence s_pwm_pa(logic [1:0] pa);
    (shadow.op_mode_sel == ptp_pkg::PTP_MODE_PWM && shadow.pin_action_sel == pa) [*3];
  endsequence
  a_ack_timely: assert property (s_take |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("data not idle");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !timer_out_o)
    else $error("reset not quiet");
  a_force_low: assert property (s_pwm_pa(ptp_pkg::PA_00) |-> !timer_out_o)
    else $error("pin not forced low");
  a_force_high: assert property (s_pwm_pa(ptp_pkg::PA_01) |-> timer_out_o)
    else $error("pin not forced high");
  a_cap_quiet: assert property (
    (shadow.op_mode_sel == ptp_pkg::PTP_MODE_CAP) [*3] |-> !timer_out_o)
    else $error("output moved in capture");
endmodule : ptp_chk

bind ptp_timer ptp_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_out_o(timer_out_o));

// File: tb/ptp_pins.sv
// pin source model: trigger and capture signals outside the timer
module ptp_pins (
  // clock
  input wire logic clk_i,
  // pins toward the timer, idle low
  output logic trig_o,
  output logic cap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    trig_o = 1'b0;
    cap_o = 1'b0;
  end
  // one pulse on the chosen pin, long enough to pass the synchroniser
  task automatic pulse(input logic which);
    @(posedge clk_i);
    if (which) trig_o <= 1'b1;
    else cap_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig_o <= 1'b0;
    cap_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
endmodule : ptp_pins

// File: tb/testbench.sv
// testbench: register access, pwm, single pulse and capture of the timer
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ptp_row_t;
  ptp_row_t rows [5] = '{'{8'h04, 32'h1234, 32'h1234}, '{8'h08, 32'habcd, 32'habcd},
    '{8'h04, 32'hffff5a5a, 32'h5a5a}, '{8'h0c, 32'h7777, 32'h0}, '{8'h14, 32'hffff, 32'h0}};
  int pwm_exp [3] = '{2, 8, 6}; // high cycles in two periods
  logic clk_i, rst_i, cyc, stb, we, trig, cap, tout, ack;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [31:0] rdat_w; // read data as driven
  int fail_count = 0; // mismatches seen
  int samples_checked = 0; // comparisons made
  int cycles = 0; // hang guard count
  int h;
  ptp_pkg::ptp_ctrl_t c;
  ptp_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat_w),
    .wb_ack_o(ack), .ext_trigger_pin_i(trig), .capture_in_pin_i(cap), .timer_out_o(tout));
  ptp_pins i_pins (.clk_i(clk_i), .trig_o(trig), .cap_o(cap));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // wait for the answer; only the hang guard ends a wait
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = rdat_w;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  // control word write
  task automatic cfg(input ptp_pkg::ptp_mode_t m, input logic [1:0] pa, input logic lv, iv,
      run, src);
    c = ptp_pkg::CTRL_RST;
    c.op_mode_sel = m;
    c.pin_action_sel = pa;
    c.out_init_level = lv;
    c.out_invert = iv;
    c.clear_src_sel = iv;
    c.counter_run = run;
    c.capture_src_sel = src;
    bus(ptp_pkg::OFS_CTRL, 1'b1, 32'(c));
  endtask : cfg
  // count high output cycles
  task automatic hi_cnt(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clk_i);
      h += (tout === 1'b1);
    end
  endtask : hi_cnt
  initial begin
    {rst_i, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 32'h0);
      `CHK(rdat, rows[i].e)
    end
    // pwm: short duty, full duty, inverted with clear source set
    bus(ptp_pkg::OFS_CMP_P, 1'b1, 32'h4);
    for (int i = 0; i < 3; i++) begin
      bus(ptp_pkg::OFS_CMP_A, 1'b1, (i == 1) ? 32'h4 : 32'h1);
      cfg(ptp_pkg::PTP_MODE_PWM, ptp_pkg::PA_10, 1'b1, i == 2, 1'b1, 1'b0);
      repeat (4) @(posedge clk_i);
      hi_cnt(8);
      `CHK(h, pwm_exp[i])
    end
    cfg(ptp_pkg::PTP_MODE_PWM, ptp_pkg::PA_00, 1'b1, 1'b0, 1'b1, 1'b0);
    repeat (6) @(posedge clk_i);
    cfg(ptp_pkg::PTP_MODE_PWM, ptp_pkg::PA_01, 1'b1, 1'b0, 1'b1, 1'b0);
    bus(ptp_pkg::OFS_COUNT, 1'b0, 32'h0);
    q = rdat;
    bus(ptp_pkg::OFS_COUNT, 1'b0, 32'h0);
    `CHK(rdat != q, 1'b1)
    // single pulse by software, then by trigger pin
    bus(ptp_pkg::OFS_CMP_A, 1'b1, 32'h5);
    cfg(ptp_pkg::PTP_MODE_PWM, ptp_pkg::PA_11, 1'b1, 1'b0, 1'b0, 1'b0);
    cfg(ptp_pkg::PTP_MODE_PWM, ptp_pkg::PA_11, 1'b1, 1'b0, 1'b1, 1'b0);
    hi_cnt(20);
    `CHK(h >= 4 && h <= 7, 1'b1)
    bus(ptp_pkg::OFS_CTRL, 1'b0, 32'h0);
    `CHK(rdat[8], 1'b0)
    bus(ptp_pkg::OFS_COUNT, 1'b0, 32'h0);
    `CHK(rdat[15:0] >= 16'h5, 1'b1)
    bus(ptp_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK(rdat[0], 1'b1)
    bus(ptp_pkg::OFS_STATUS, 1'b1, 32'h3);
    bus(ptp_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK(rdat[1:0], 2'h0)
    fork
      i_pins.pulse(1'b1);
      hi_cnt(24);
    join
    `CHK(h >= 4 && h <= 7, 1'b1)
    // capture: every edge code, both source pins
    bus(ptp_pkg::OFS_CMP_P, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cfg(ptp_pkg::PTP_MODE_CAP, 2'(i), 1'b1, 1'b1, 1'b1, i[0]);
      bus(ptp_pkg::OFS_CMP_A, 1'b1, 32'h0);
      bus(ptp_pkg::OFS_STATUS, 1'b1, 32'h3);
      i_pins.pulse(i[0]);
      bus(ptp_pkg::OFS_STATUS, 1'b0, 32'h0);
      `CHK(rdat[0], i != 3)
      bus(ptp_pkg::OFS_CMP_A, 1'b0, 32'h0);
      `CHK(rdat[15:0] != 16'h0, i != 3)
    end
    cfg(ptp_pkg::PTP_MODE_CAP, ptp_pkg::PA_11, 1'b0, 1'b0, 1'b0, 1'b0);
    bus(ptp_pkg::OFS_CMP_P, 1'b1, 32'h3);
    cfg(ptp_pkg::PTP_MODE_CAP, ptp_pkg::PA_11, 1'b0, 1'b0, 1'b1, 1'b0);
    bus(ptp_pkg::OFS_STATUS, 1'b1, 32'h3);
    repeat (10) @(posedge clk_i);
    bus(ptp_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK(rdat[1], 1'b1)
    bus(ptp_pkg::OFS_COUNT, 1'b0, 32'h0);
    `CHK(rdat[15:0] <= 16'h3, 1'b1)
    // second reset in mid-run clears everything
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 16; a += 4) begin
      bus(8'(a), 1'b0, 32'h0);
      `CHK(rdat, 32'h0)
    end
    `CHK(tout, 1'b0)
    tally_and_finish();
  end
endmodule : testbench
